// [kms_chk.sv]
// Port checker of the keyboard matrix scanner
`timescale 1ns/1ns
module kms_chk (
    // Clock and reset
    input wire logic                             pclk,
    input wire logic                             presetn,
    // APB
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [kms_pkg::KMS_ADDR_W-1:0]   paddr,
    input wire logic [kms_pkg::KMS_DATA_W-1:0]   pwdata,
    input wire logic [kms_pkg::KMS_DATA_W-1:0]   prdata,
    input wire logic                             pready,
    input wire logic                             pslverr,
    // Matrix and clock request
    input wire logic [kms_pkg::KMS_MAX_ROWS-1:0] row_in,
    input wire logic [kms_pkg::KMS_MAX_COLS-1:0] col_out,
    input wire logic                             clk_ext_on,
    input wire logic                             clk_req
);
    import kms_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_cause_a: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
        else $error("unmapped address accepted");
    rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == '0)
        else $error("read data outside read");
    one_col_a: assert property ($countones(~col_out) <= 1)
        else $error("several columns low");
    req_rise_a: assert property ($rose(clk_req) |-> !$past(clk_ext_on))
        else $error("clock request with clock on");
    idle_cols_a: assert property ($fell(clk_req) |-> ##[0:1] (&col_out))
        else $error("columns not high in idle");
    col_clk_a: assert property (!(&col_out) |-> clk_req || clk_ext_on || $past(clk_req))
        else $error("scanning without clock");
    cover property ($rose(clk_req));
    cover property (pslverr);
    cover property (!col_out[19]);
endmodule

bind kms_scanner kms_chk u_kms_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .row_in(row_in), .col_out(col_out),
    .clk_ext_on(clk_ext_on), .clk_req(clk_req));

// [kms_matrix.sv]
// Key switch matrix model with a contact transient on press
`timescale 1ns/1ns
module kms_matrix (
    // Clock
    input  wire logic         pclk,
    // Matrix lines
    input  wire logic [19:0]  col_out,
    output logic      [7:0]   row_in,
    // Pressed keys, index column*8+row
    input  wire logic [159:0] keys
);
    logic [159:0] prev = '0;
    logic [7:0]   live;
    logic [7:0]   fresh;
    logic [7:0]   wrow = '0;
    logic [3:0]   wcnt = '0;
    // Rows pulled up; a new press jolts its row low to wake the idle scanner
    always_comb begin
        live  = 8'hff;
        fresh = 8'h00;
        for (int i = 0; i < 160; i++) begin
            if (keys[i] && !col_out[i/8]) live[i%8] = 1'b0;
            if (keys[i] && !prev[i]) fresh[i%8] = 1'b1;
        end
    end
    always_ff @(posedge pclk) begin
        prev <= keys;
        if (|fresh) begin
            wcnt <= 4'd12;
            wrow <= fresh;
        end else if (wcnt != 4'd0) begin
            wcnt <= wcnt - 4'd1;
        end
    end
    assign row_in = live & ~((wcnt != 4'd0) ? wrow : 8'h00);
endmodule

// [kms_pkg.sv]
// Shared constants and types of the keyboard matrix scanner
package kms_pkg;
    // ****************************************
    // Matrix and buffer geometry
    // ****************************************
    localparam int KMS_MAX_ROWS  = 8;
    localparam int KMS_MAX_COLS  = 20;
    localparam int KMS_MAX_KEYS  = 160;
    localparam int KMS_BUF_DEPTH = 16;
    localparam int KMS_CODE_W    = 8;
    localparam int KMS_NUM_MODS  = 8;
    localparam int KMS_COL_W     = 5;
    localparam int KMS_ROW_W     = 3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int PCLK_KHZ      = 125000;
    localparam int SCAN_CLK_KHZ  = 128;
    localparam int KMS_TICK_CYC  = PCLK_KHZ / SCAN_CLK_KHZ;
    localparam int KMS_HIT_MULTI = 2;

    // ****************************************
    // Register map
    // ****************************************
    localparam int KMS_ADDR_W = 8;
    localparam int KMS_DATA_W = 32;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_CTRL   = 8'h00;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_STATUS = 8'h04;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_DATA   = 8'h08;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_MODA   = 8'h0c;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_MODB   = 8'h10;
    localparam logic [KMS_ADDR_W-1:0] KMS_ADDR_MODS   = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_COLS_LSB  = 8;
    localparam int CTRL_ROWS_LSB  = 16;
    localparam int STS_GHOST_BIT  = 0;
    localparam int STS_OVF_BIT    = 1;
    localparam int STS_CNT_LSB    = 8;
    localparam int STS_STATE_LSB  = 16;
    localparam int STS_CREQ_BIT   = 18;
    localparam int DATA_VALID_BIT = 8;
    localparam logic [KMS_COL_W-1:0]  CTRL_COLS_RST = 5'h13;
    localparam logic [KMS_ROW_W-1:0]  CTRL_ROWS_RST = 3'h7;
    localparam logic [KMS_DATA_W-1:0] MOD_RST       = 32'hffffffff;

    typedef enum logic [1:0] {
        KMS_IDLE = 2'b00,
        KMS_SCAN = 2'b01,
        KMS_END  = 2'b11
    } kms_state_e;
endpackage

// [kms_scanner.sv]
// Keyboard matrix scanner with APB register access
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns

// What this block does
// [R1] Scan up to eight rows by twenty columns
// [R2] Column count programmable one to twenty
// [R3] Row count programmable one to eight
// [R4] Key codes stored in sixteen-entry buffer
// [R5] Scan steps at a 128 kHz rate
// [R6] Clock request dropped when no key pressed
// [R7] Any number of keys; ghost keys locked out
// [R8] Codes kept until read or reset
// [R9] Row inputs filtered and debounced before detection
// [R10] Idle first; all columns driven high
// [R11] Row transition in idle requests clock, scans
// [R12] Row-hit and key index cleared in idle
// [R13] Row counter wraps, then column advances
// [R14] Row and column terminal counts together lead to scan end
// [R15] Key index increments per scanned position
// [R16] Modifiers matched; others written to buffer
// [R17] Row-hit ORed only on multi-hit columns
// [R18] Hit in row of earlier column sets ghost
// [R19] Scan end rescans on keys, else idles
// [R20] Firmware polls status register for results
// [R21] Full buffer drops code and flags overflow
// [R22] Only selected column driven low
module kms_scanner #(
    parameter int BUF_DEPTH = kms_pkg::KMS_BUF_DEPTH,
    parameter int TICK_CYC  = kms_pkg::KMS_TICK_CYC
) (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [kms_pkg::KMS_ADDR_W-1:0]    paddr,
    input  wire logic [kms_pkg::KMS_DATA_W-1:0]    pwdata,
    output logic      [kms_pkg::KMS_DATA_W-1:0]    prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Key matrix
    input  wire logic [kms_pkg::KMS_MAX_ROWS-1:0]  row_in,
    output logic      [kms_pkg::KMS_MAX_COLS-1:0]  col_out,
    // Scan clock request
    input  wire logic                              clk_ext_on,
    output logic                                   clk_req
);
    import kms_pkg::*;

    // ****************************************
    // Local constants
    // ****************************************
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    localparam logic [TW-1:0] DIV_LAST = TW'(TICK_CYC - 1);
    localparam logic [PW:0]   BUF_FULL = (PW + 1)'(BUF_DEPTH);
    localparam logic [KMS_COL_W-1:0] COL_LAST_MAX = KMS_COL_W'(KMS_MAX_COLS - 1);
    localparam logic [3:0] HIT_MULTI = 4'(KMS_HIT_MULTI);

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [KMS_MAX_ROWS-1:0] row_mask(input logic [KMS_ROW_W-1:0] last);
        logic [KMS_MAX_ROWS-1:0] m;
        m = '0;
        for (int i = 0; i < KMS_MAX_ROWS; i++) begin
            m[i] = (KMS_ROW_W'(i) <= last);
        end
        return m;
    endfunction

    function automatic logic [3:0] pop_count(input logic [KMS_MAX_ROWS-1:0] v);
        logic [3:0] n;
        n = '0;
        for (int i = 0; i < KMS_MAX_ROWS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    function automatic logic [KMS_NUM_MODS-1:0] mod_match(
        input logic [2*KMS_DATA_W-1:0] codes,
        input logic [KMS_CODE_W-1:0]   idx
    );
        logic [KMS_NUM_MODS-1:0] m;
        m = '0;
        for (int i = 0; i < KMS_NUM_MODS; i++) begin
            m[i] = (codes[i*KMS_CODE_W +: KMS_CODE_W] == idx);
        end
        return m;
    endfunction

    function automatic logic addr_ok(input logic [KMS_ADDR_W-1:0] a);
        return (a == KMS_ADDR_CTRL) || (a == KMS_ADDR_STATUS) ||
               (a == KMS_ADDR_DATA) || (a == KMS_ADDR_MODA) ||
               (a == KMS_ADDR_MODB) || (a == KMS_ADDR_MODS);
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    kms_state_e                 state;
    logic [KMS_MAX_ROWS-1:0]    row_s1;
    logic [KMS_MAX_ROWS-1:0]    row_s2;
    logic [KMS_MAX_ROWS-1:0]    row_s3;
    logic [KMS_MAX_ROWS-1:0]    row_f;
    logic [KMS_MAX_ROWS-1:0]    row_f_q;
    logic                       ctrl_en;
    logic [KMS_COL_W-1:0]       ctrl_cols;
    logic [KMS_ROW_W-1:0]       ctrl_rows;
    logic [2*KMS_DATA_W-1:0]    mod_codes;
    logic [KMS_NUM_MODS-1:0]    mod_down;
    logic                       ghost_flag;
    logic                       ovf_flag;
    logic [TW-1:0]              div_cnt;
    logic                       tick;
    logic [KMS_ROW_W-1:0]       row_cnt;
    logic [KMS_COL_W-1:0]       col_cnt;
    logic [KMS_CODE_W-1:0]      key_idx;
    logic [KMS_MAX_ROWS-1:0]    row_hit;
    logic                       any_hit;
    logic [KMS_MAX_KEYS-1:0]    seen_prev;
    logic [KMS_MAX_KEYS-1:0]    key_down;
    logic [KMS_CODE_W-1:0]      buf_mem [BUF_DEPTH];
    logic [PW-1:0]              wr_ptr;
    logic [PW-1:0]              rd_ptr;
    logic [PW:0]                buf_cnt;

    logic                       setup;
    logic                       wr_done;
    logic                       rd_done;
    logic [KMS_DATA_W-1:0]      rd_val;
    logic [KMS_COL_W-1:0]       col_last;
    logic [KMS_MAX_ROWS-1:0]    row_vec;
    logic                       row_chg;
    logic                       clk_ok;
    logic                       step;
    logic                       key_now;
    logic                       press_ev;
    logic                       ghost_ev;
    logic                       report;
    logic                       release_ev;
    logic [KMS_NUM_MODS-1:0]    mod_hit;
    logic                       push;
    logic                       push_ok;
    logic                       pop;
    logic                       buf_full;
    logic                       go_scan;
    logic                       go_idle;

    // ****************************************
    // Row input filtering
    // ****************************************
    // Third stage must agree with second before the filtered value moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_s1  <= '1;
            row_s2  <= '1;
            row_s3  <= '1;
            row_f   <= '1;
            row_f_q <= '1;
        end else begin
            row_s1  <= row_in;
            row_s2  <= row_s1;
            row_s3  <= row_s2;
            row_f_q <= row_f;
            if (row_s2 == row_s3) begin
                row_f <= row_s3; // [R9]
            end
        end
    end

    // ****************************************
    // Decode of scan conditions
    // ****************************************
    assign col_last = (ctrl_cols > COL_LAST_MAX) ? COL_LAST_MAX : ctrl_cols; // [R1] [R2]
    assign row_vec  = ~row_f & row_mask(ctrl_rows); // [R3]
    assign row_chg  = (row_f != row_f_q);
    assign clk_ok   = clk_req | clk_ext_on;
    assign step     = (state == KMS_SCAN) && tick && ctrl_en;
    assign key_now  = row_vec[row_cnt];

    // Key must be seen on two passes running before it is reported
    assign press_ev   = step && key_now && seen_prev[key_idx] && !key_down[key_idx]; // [R9]
    assign ghost_ev   = press_ev && row_hit[row_cnt]; // [R18]
    assign report     = press_ev && !ghost_ev; // [R7]
    assign release_ev = step && !key_now && !seen_prev[key_idx] && key_down[key_idx];
    assign mod_hit    = mod_match(mod_codes, key_idx); // [R16]
    assign push       = report && (mod_hit == '0); // [R16]
    assign buf_full   = (buf_cnt == BUF_FULL);
    assign push_ok    = push && !buf_full; // [R21]

    assign go_scan = (state == KMS_IDLE) && ctrl_en && row_chg; // [R11]
    assign go_idle = ((state != KMS_IDLE) && !ctrl_en) ||
                     ((state == KMS_END) && !any_hit); // [R19]

    // ****************************************
    // Scan rate divider
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if ((state == KMS_IDLE) || !clk_ok) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
            tick    <= 1'b1; // [R5]
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick    <= 1'b0;
        end
    end

    // ****************************************
    // Scan state machine and counters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= KMS_IDLE; // [R10]
            row_cnt <= '0;
            col_cnt <= '0;
            key_idx <= '0;
            row_hit <= '0;
            any_hit <= 1'b0;
        end else if (go_idle) begin
            state <= KMS_IDLE;
        end else begin
            case (state)
                KMS_IDLE: begin
                    row_cnt <= '0;
                    col_cnt <= '0;
                    key_idx <= '0; // [R12]
                    row_hit <= '0; // [R12]
                    any_hit <= 1'b0;
                    if (go_scan) begin
                        state <= KMS_SCAN; // [R11]
                    end
                end
                KMS_SCAN: begin
                    if (step) begin
                        key_idx <= key_idx + 1'b1; // [R15]
                        any_hit <= any_hit | key_now;
                        if (row_cnt == ctrl_rows) begin
                            row_cnt <= '0; // [R13]
                            if (pop_count(row_vec) >= HIT_MULTI) begin
                                row_hit <= row_hit | row_vec; // [R17]
                            end
                            if (col_cnt == col_last) begin
                                state <= KMS_END; // [R14]
                            end else begin
                                col_cnt <= col_cnt + 1'b1; // [R13]
                            end
                        end else begin
                            row_cnt <= row_cnt + 1'b1; // [R13]
                        end
                    end
                end
                KMS_END: begin
                    // Keys still present: start a fresh pass
                    state   <= KMS_SCAN; // [R19]
                    row_cnt <= '0;
                    col_cnt <= '0;
                    key_idx <= '0;
                    row_hit <= '0;
                    any_hit <= 1'b0;
                end
                default: begin
                    state <= KMS_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Column drive and clock request
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col_out <= '1;
        end else if (state == KMS_SCAN) begin
            col_out <= ~(KMS_MAX_COLS'(1) << col_cnt); // [R22]
        end else begin
            col_out <= '1; // [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_req <= 1'b0;
        end else if (go_scan) begin
            clk_req <= !clk_ext_on; // [R11]
        end else if (go_idle) begin
            clk_req <= 1'b0; // [R6] [R19]
        end
    end

    // ****************************************
    // Per-key debounce state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_prev <= '0;
            key_down  <= '0;
        end else if (go_idle) begin
            seen_prev <= '0;
            key_down  <= '0;
        end else if (step) begin
            seen_prev[key_idx] <= key_now; // [R9]
            if (press_ev) begin
                key_down[key_idx] <= 1'b1; // [R7]
            end else if (release_ev) begin
                key_down[key_idx] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_down <= '0;
        end else if (go_idle) begin
            mod_down <= '0;
        end else if (report && (mod_hit != '0)) begin
            mod_down <= mod_down | mod_hit; // [R16]
        end else if (release_ev) begin
            mod_down <= mod_down & ~mod_hit;
        end
    end

    // ****************************************
    // Key-code buffer
    // ****************************************
    assign pop = rd_done && (paddr == KMS_ADDR_DATA) && prdata[DATA_VALID_BIT]; // [R8]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_mem[i] <= '0;
            end
        end else if (push_ok) begin
            buf_mem[wr_ptr] <= key_idx; // [R4]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            buf_cnt <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push_ok && !pop) begin
                buf_cnt <= buf_cnt + 1'b1; // [R4]
            end else if (pop && !push_ok) begin
                buf_cnt <= buf_cnt - 1'b1; // [R8]
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Set beats a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ghost_flag <= 1'b0;
        end else if (ghost_ev) begin
            ghost_flag <= 1'b1; // [R18]
        end else if (wr_done && (paddr == KMS_ADDR_STATUS) && pwdata[STS_GHOST_BIT]) begin
            ghost_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag <= 1'b0;
        end else if (push && buf_full) begin
            ovf_flag <= 1'b1; // [R21]
        end else if (wr_done && (paddr == KMS_ADDR_STATUS) && pwdata[STS_OVF_BIT]) begin
            ovf_flag <= 1'b0;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite;

    always_comb begin
        rd_val = '0;
        if (paddr == KMS_ADDR_CTRL) begin
            rd_val[CTRL_EN_BIT] = ctrl_en;
            rd_val[CTRL_COLS_LSB +: KMS_COL_W] = ctrl_cols;
            rd_val[CTRL_ROWS_LSB +: KMS_ROW_W] = ctrl_rows;
        end else if (paddr == KMS_ADDR_STATUS) begin
            rd_val[STS_GHOST_BIT] = ghost_flag; // [R20]
            rd_val[STS_OVF_BIT]   = ovf_flag;
            rd_val[STS_CNT_LSB +: PW + 1] = buf_cnt;
            rd_val[STS_STATE_LSB +: 2] = state;
            rd_val[STS_CREQ_BIT] = clk_req;
        end else if (paddr == KMS_ADDR_DATA) begin
            rd_val[KMS_CODE_W-1:0] = buf_mem[rd_ptr];
            rd_val[DATA_VALID_BIT] = (buf_cnt != '0);
        end else if (paddr == KMS_ADDR_MODA) begin
            rd_val = mod_codes[KMS_DATA_W-1:0];
        end else if (paddr == KMS_ADDR_MODB) begin
            rd_val = mod_codes[2*KMS_DATA_W-1:KMS_DATA_W];
        end else if (paddr == KMS_ADDR_MODS) begin
            rd_val[KMS_NUM_MODS-1:0] = mod_down;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_ok(paddr);
            prdata  <= (setup && !pwrite) ? rd_val : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en   <= 1'b0;
            ctrl_cols <= CTRL_COLS_RST;
            ctrl_rows <= CTRL_ROWS_RST;
            mod_codes <= {MOD_RST, MOD_RST};
        end else if (wr_done) begin
            if (paddr == KMS_ADDR_CTRL) begin
                ctrl_en   <= pwdata[CTRL_EN_BIT];
                ctrl_cols <= pwdata[CTRL_COLS_LSB +: KMS_COL_W]; // [R2]
                ctrl_rows <= pwdata[CTRL_ROWS_LSB +: KMS_ROW_W]; // [R3]
            end else if (paddr == KMS_ADDR_MODA) begin
                mod_codes[KMS_DATA_W-1:0] <= pwdata;
            end else if (paddr == KMS_ADDR_MODB) begin
                mod_codes[2*KMS_DATA_W-1:KMS_DATA_W] <= pwdata;
            end
        end
    end
endmodule

// [tb_top.sv]
// Testbench of the keyboard matrix scanner
`timescale 1ns/1ns
module tb_top;
    import kms_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = '0;
    logic [31:0]  pwdata = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [7:0]   row_in;
    logic [19:0]  col_out;
    logic         clk_ext_on = 1'b0;
    logic         clk_req;
    logic [159:0] keys = '0;
    logic [31:0]  rd;
    logic         err;
    int           bad_count = 0;
    int           checks = 0;
    always #4 pclk = ~pclk;
    kms_scanner #(.BUF_DEPTH(KMS_BUF_DEPTH), .TICK_CYC(8)) u_kms_scanner (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .row_in(row_in), .col_out(col_out), .clk_ext_on(clk_ext_on), .clk_req(clk_req));
    kms_matrix u_kms_matrix (.pclk(pclk), .col_out(col_out), .row_in(row_in), .keys(keys));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== v && n < 2000);
        chk(rd & m, v, "poll");
    endtask
    task automatic do_reset(input logic [2:0] rm1, input logic [4:0] cm1);
        presetn <= 1'b0;
        keys <= '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, KMS_ADDR_CTRL, {13'h0, rm1, 3'h0, cm1, 7'h0, 1'b1});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        do_reset(3'h0, 5'h0);
        chk({12'h0, col_out}, 32'h000fffff, "idle cols");
        chk({31'h0, clk_req}, 32'h0, "idle req");
        apb(1'b1, KMS_ADDR_CTRL, 32'h0);
        apb(1'b0, KMS_ADDR_STATUS, 32'h0);
        chk(rd, 32'h0, "status");
        apb(1'b0, KMS_ADDR_MODA, 32'h0);
        chk(rd, MOD_RST, "moda");
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        apb(1'b1, KMS_ADDR_DATA, 32'h1ff);
        apb(1'b0, KMS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0, "empty data");
    endtask
    task automatic t_corner;
        do_reset(3'h7, 5'h13);
        keys[159] <= 1'b1;
        poll(KMS_ADDR_STATUS, 32'h00070000, 32'h00050000);
        poll(KMS_ADDR_DATA, 32'h1ff, 32'h19f);
        keys <= '0;
        poll(KMS_ADDR_STATUS, 32'h00070000, 32'h0);
        chk({12'h0, col_out}, 32'h000fffff, "cols after scan");
    endtask
    task automatic t_small;
        do_reset(3'h0, 5'h0);
        clk_ext_on <= 1'b1;
        keys[0] <= 1'b1;
        keys[8] <= 1'b1;
        poll(KMS_ADDR_STATUS, 32'h00070000, 32'h00010000);
        poll(KMS_ADDR_DATA, 32'h1ff, 32'h100);
        repeat (100) @(posedge pclk);
        apb(1'b0, KMS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0, "column outside count");
        clk_ext_on <= 1'b0;
    endtask
    task automatic t_ghost;
        do_reset(3'h1, 5'h1);
        keys[0] <= 1'b1;
        keys[1] <= 1'b1;
        keys[8] <= 1'b1;
        poll(KMS_ADDR_STATUS, 32'h1, 32'h1);
        poll(KMS_ADDR_DATA, 32'h1ff, 32'h100);
        poll(KMS_ADDR_DATA, 32'h1ff, 32'h101);
        repeat (200) @(posedge pclk);
        apb(1'b0, KMS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0, "ghost key locked");
        keys <= '0;
        poll(KMS_ADDR_STATUS, 32'h00070000, 32'h0);
        apb(1'b1, KMS_ADDR_STATUS, 32'h1);
        apb(1'b0, KMS_ADDR_STATUS, 32'h0);
        chk(rd & 32'h1, 32'h0, "ghost cleared");
    endtask
    task automatic t_overflow;
        do_reset(3'h7, 5'h10);
        for (int c = 0; c < 17; c++) keys[c*8] <= 1'b1;
        poll(KMS_ADDR_STATUS, 32'h1f02, 32'h1002);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, KMS_ADDR_DATA, 32'h0);
            chk(rd, 32'h100 | (i * 8), "buffered code");
        end
        apb(1'b0, KMS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0, "dropped code");
    endtask
    task automatic t_modifier;
        do_reset(3'h1, 5'h2);
        apb(1'b1, KMS_ADDR_MODA, 32'hffffff05);
        keys[17] <= 1'b1;
        keys[9] <= 1'b1;
        poll(KMS_ADDR_MODS, 32'hff, 32'h01);
        poll(KMS_ADDR_DATA, 32'h1ff, 32'h103);
        repeat (100) @(posedge pclk);
        apb(1'b0, KMS_ADDR_DATA, 32'h0);
        chk(rd, 32'h0, "modifier not buffered");
    endtask
    task automatic stop_test;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #480000;
        bad_count++;
        stop_test();
    end
    initial begin
        t_reset();
        t_corner();
        t_small();
        t_ghost();
        t_overflow();
        t_modifier();
        stop_test();
    end
endmodule
